// ==== verif/ctrl_model.sv ====
`timescale 1ns/1ps
// ********************************
// memory controller model
// ********************************
module ctrl_model (
	input  wire logic  clk,
	output logic       clock_enable,
	output logic       chip_select_n,
	output logic       row_strobe_n,
	output logic       column_strobe_n,
	output logic       write_enable_n,
	output logic [1:0] bank_addr,
	output logic       precharge_all,
	output logic       fast_exit,
	output logic       on_die_termination
);
	initial {clock_enable, chip_select_n, row_strobe_n, column_strobe_n,
		write_enable_n, bank_addr, precharge_all, fast_exit,
		on_die_termination} = 11'h3c1;
	task automatic send(input logic k, input logic [3:0] p);
		@(posedge clk);
		#2;
		clock_enable = k;
		{chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = p;
	endtask
	task automatic set(input logic [1:0] b, input logic pa, fe, o);
		bank_addr = b;
		precharge_all = pa;
		fast_exit = fe;
		on_die_termination = o;
	endtask
	task automatic idle(input logic k, input int n);
		repeat (n) send(k, 4'h7);
	endtask
	task automatic scramble(input int n);
		for (int i = 0; i < n; i++) send(1'b0, i[0] ? 4'he : 4'h1);
	endtask
endmodule

// ==== verif/refresh_pd_monitor.sv ====
`timescale 1ns/1ps
// ********************************
// refresh and power-down checker
// ********************************
module refresh_pd_monitor #(
	parameter int unsigned ROW_BITS  = 13,
	parameter int unsigned BANK_BITS = 2
) (
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 clock_enable,
	input wire logic                 chip_select_n,
	input wire logic                 row_strobe_n,
	input wire logic                 column_strobe_n,
	input wire logic                 write_enable_n,
	input wire logic                 fast_exit,
	input wire logic                 refresh_busy,
	input wire logic [BANK_BITS-1:0] refresh_bank,
	input wire logic [ROW_BITS-1:0]  refresh_row,
	input wire logic                 dll_enable,
	input wire logic                 internal_clock_on,
	input wire logic                 self_refresh_active,
	input wire logic                 power_down_active,
	input wire logic                 active_power_down,
	input wire logic                 banks_open_any,
	input wire logic                 ready_for_command
);
	logic ref_p;
	logic nop_p;
	assign ref_p = !chip_select_n && !row_strobe_n && !column_strobe_n
		&& write_enable_n;
	assign nop_p = chip_select_n
		|| (row_strobe_n && column_strobe_n && write_enable_n);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_ref; $past(clock_enable) && clock_enable && ref_p
		&& ready_for_command |=> refresh_busy && !ready_for_command; endproperty
	a_ref: assert property (p_ref) else $error("refresh not started");
	property p_len; $rose(refresh_busy) && !self_refresh_active
		|-> refresh_busy[*3] ##1 !refresh_busy; endproperty
	a_len: assert property (p_len) else $error("refresh length wrong");
	property p_cnt; $rose(refresh_busy) && !self_refresh_active |-> ##4
		({refresh_row, refresh_bank} == $past({refresh_row, refresh_bank}, 4)
		+ 1'b1); endproperty
	a_cnt: assert property (p_cnt) else $error("counter not stepped");
	property p_sre; $past(clock_enable) && !clock_enable && ref_p
		&& ready_for_command |=> self_refresh_active && !dll_enable
		&& refresh_busy; endproperty
	a_sre: assert property (p_sre) else $error("self refresh entry");
	property p_gate; $rose(self_refresh_active)
		|-> ##[1:4] !internal_clock_on; endproperty
	a_gate: assert property (p_gate) else $error("clock not gated");
	property p_hold; self_refresh_active && !clock_enable
		|=> self_refresh_active; endproperty
	a_hold: assert property (p_hold) else $error("self refresh left");
	property p_srx; self_refresh_active && clock_enable
		|=> !self_refresh_active ##[0:4] dll_enable; endproperty
	a_srx: assert property (p_srx) else $error("self refresh exit");
	property p_xwait; $fell(self_refresh_active)
		|-> !ready_for_command[*3] ##[1:2] ready_for_command; endproperty
	a_xwait: assert property (p_xwait) else $error("exit delay");
	property p_ppd; $past(clock_enable) && !clock_enable && nop_p
		&& ready_for_command && !banks_open_any |=> power_down_active
		&& !active_power_down && !dll_enable; endproperty
	a_ppd: assert property (p_ppd) else $error("precharge pd");
	property p_apd; $past(clock_enable) && !clock_enable && nop_p
		&& ready_for_command && banks_open_any |=> active_power_down
		&& (dll_enable == $past(fast_exit)); endproperty
	a_apd: assert property (p_apd) else $error("active pd");
	property p_pdx; power_down_active && clock_enable && nop_p
		|=> !power_down_active ##[1:3] ready_for_command; endproperty
	a_pdx: assert property (p_pdx) else $error("pd exit");
endmodule
bind refresh_pd_ctrl refresh_pd_monitor #(.ROW_BITS(ROW_BITS),
	.BANK_BITS(BANK_BITS)) u_refresh_pd_monitor (.clk, .rst_n,
	.clock_enable, .chip_select_n, .row_strobe_n, .column_strobe_n,
	.write_enable_n, .fast_exit, .refresh_busy, .refresh_bank,
	.refresh_row, .dll_enable, .internal_clock_on, .self_refresh_active,
	.power_down_active, .active_power_down, .banks_open_any,
	.ready_for_command);

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
// ********************************
// testbench
// ********************************
module testbench;
	logic clk, rst_n, clock_enable, chip_select_n, row_strobe_n;
	logic column_strobe_n, write_enable_n, precharge_all, fast_exit;
	logic refresh_busy, dll_enable, internal_clock_on, self_refresh_active;
	logic power_down_active, active_power_down, banks_open_any;
	logic ready_for_read, ready_for_command;
	logic [1:0] bank_addr, refresh_bank;
	logic [12:0] refresh_row;
	int miscompares, checked;
	refresh_pd_ctrl u_refresh_pd_ctrl (.clk, .rst_n, .clock_enable,
		.chip_select_n, .row_strobe_n, .column_strobe_n, .write_enable_n,
		.bank_addr, .precharge_all, .fast_exit, .refresh_busy, .refresh_bank,
		.refresh_row, .dll_enable, .internal_clock_on, .self_refresh_active,
		.power_down_active, .active_power_down, .banks_open_any,
		.ready_for_read, .ready_for_command);
	ctrl_model u_ctrl_model (.clk, .clock_enable, .chip_select_n,
		.row_strobe_n, .column_strobe_n, .write_enable_n, .bank_addr,
		.precharge_all, .fast_exit, .on_die_termination());
	task automatic check(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic t_refresh;
		for (int i = 1; i < 3; i++) begin
			u_ctrl_model.send(1'b1, 4'h1);
			u_ctrl_model.send(1'b1, 4'h7);
			check("busy", {refresh_busy, ready_for_command}, 16'h2);
			u_ctrl_model.idle(1'b1, 3);
			check("count", {banks_open_any, refresh_row, refresh_bank},
				16'(i));
		end
	endtask
	task automatic t_self;
		u_ctrl_model.set(2'h0, 1'b0, 1'b0, 1'b0);
		u_ctrl_model.send(1'b0, 4'h1);
		u_ctrl_model.scramble(4);
		check("self", {self_refresh_active, dll_enable, internal_clock_on,
			refresh_busy}, 16'h8);
		u_ctrl_model.send(1'b1, 4'h7);
		u_ctrl_model.idle(1'b1, 4);
		check("exit", ready_for_command, 16'h0);
		u_ctrl_model.idle(1'b1, 1);
		check("ready", {ready_for_command, dll_enable, ready_for_read},
			16'h6);
		u_ctrl_model.idle(1'b1, 195);
		check("rd_wait", ready_for_read, 16'h0);
		u_ctrl_model.idle(1'b1, 1);
		check("rd_ok", ready_for_read, 16'h1);
		u_ctrl_model.send(1'b1, 4'h1);
		u_ctrl_model.send(1'b1, 4'h7);
		check("refr", {refresh_busy, ready_for_command}, 16'h2);
		u_ctrl_model.idle(1'b1, 3);
		check("refr_cnt", {banks_open_any, refresh_row, refresh_bank},
			16'h4);
	endtask
	task automatic t_pd;
		u_ctrl_model.send(1'b0, 4'h7);
		u_ctrl_model.idle(1'b0, 3);
		check("ppd", {power_down_active, active_power_down, dll_enable},
			16'h4);
		u_ctrl_model.idle(1'b1, 4);
		check("ppd_x", {power_down_active, ready_for_command}, 16'h1);
		for (int f = 1; f >= 0; f--) begin
			u_ctrl_model.set(2'h2, 1'b0, f[0], 1'b0);
			u_ctrl_model.send(1'b1, 4'h3);
			u_ctrl_model.send(1'b0, 4'h7);
			u_ctrl_model.idle(1'b0, 3);
			check("apd", {power_down_active, active_power_down, dll_enable,
				banks_open_any}, {12'h0, 2'b11, f[0], 1'b1});
			u_ctrl_model.idle(1'b1, 4);
			check("apd_x", {power_down_active, ready_for_command},
				16'h1);
			u_ctrl_model.set(2'h2, f[0], f[0], 1'b0);
			u_ctrl_model.send(1'b1, 4'h2);
			u_ctrl_model.idle(1'b1, 2);
			check("pre", banks_open_any, 16'h0);
		end
	endtask
	task automatic t_reinit;
		u_ctrl_model.send(1'b0, 4'he);
		rst_n = 1'b0;
		u_ctrl_model.idle(1'b0, 2);
		rst_n = 1'b1;
		check("reinit", {dll_enable, internal_clock_on, ready_for_command,
			refresh_busy, self_refresh_active, power_down_active,
			banks_open_any, refresh_bank}, 16'h1c0);
		check("reinit_row", refresh_row, 16'h0);
		u_ctrl_model.idle(1'b1, 2);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#50000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#2;
		rst_n = 1'b1;
		check("reset", {dll_enable, internal_clock_on, ready_for_command,
			refresh_busy, self_refresh_active, power_down_active,
			banks_open_any, refresh_bank}, 16'h1c0);
		u_ctrl_model.idle(1'b1, 2);
		t_refresh;
		t_self;
		t_pd;
		t_reinit;
		report_and_stop;
	end
endmodule

// ==== verilog/cmd_decode.sv ====
`timescale 1ns/1ps
module cmd_decode (
	input  wire logic                  cke_prev,
	input  wire logic                  clock_enable,
	input  wire logic                  chip_select_n,
	input  wire logic                  row_strobe_n,
	input  wire logic                  column_strobe_n,
	input  wire logic                  write_enable_n,
	output refresh_pd_pkg::cmd_e       cmd
);
	import refresh_pd_pkg::*;

	// ************************************************************
	// command decode on clock enable history
	// ************************************************************
	always_comb begin
		cmd = CMD_NOP;
		if (cke_prev && !clock_enable) begin
			if (!chip_select_n && !row_strobe_n && !column_strobe_n &&
			    write_enable_n)
				cmd = CMD_SELF;
			else
				cmd = CMD_PD_ENTER;
		end else if (cke_prev && !chip_select_n) begin
			unique case ({row_strobe_n, column_strobe_n, write_enable_n})
				3'b001:  cmd = CMD_REFRESH;
				3'b011:  cmd = CMD_ACTIVATE;
				3'b010:  cmd = CMD_PRECHG;
				3'b111:  cmd = CMD_NOP;
				default: cmd = CMD_OTHER;
			endcase
		end
	end
endmodule

// ==== verilog/refresh_pd_ctrl.sv ====
// Contract
// - refresh decoded: cs,ras,cas low, cke,we high
// - internal counter addresses refresh, banks idle after
// - self refresh decoded with cke low
// - in self refresh only clock_enable matters
// - dll off in self refresh, back on exit
// - internal refresh within pulse; clock gated
// - dll locked at power-down entry, else reset; lock not checked at entry, no dll reset done
// - precharge or active power-down; dll per mode
// - power-down ends on cke high with nop
`timescale 1ns/1ps
module refresh_pd_ctrl #(
	parameter int unsigned ROW_BITS  = 13,
	parameter int unsigned BANK_BITS = 2
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 clock_enable,
	input  wire logic                 chip_select_n,
	input  wire logic                 row_strobe_n,
	input  wire logic                 column_strobe_n,
	input  wire logic                 write_enable_n,
	input  wire logic [BANK_BITS-1:0] bank_addr,
	input  wire logic                 precharge_all,
	input  wire logic                 fast_exit,
	output logic                      refresh_busy,
	output logic [BANK_BITS-1:0]      refresh_bank,
	output logic [ROW_BITS-1:0]       refresh_row,
	output logic                      dll_enable,
	output logic                      internal_clock_on,
	output logic                      self_refresh_active,
	output logic                      power_down_active,
	output logic                      active_power_down,
	output logic                      banks_open_any,
	output logic                      ready_for_read,
	output logic                      ready_for_command
);
	import refresh_pd_pkg::*;

	if (ROW_BITS < 1 || ROW_BITS > 16 || BANK_BITS != 2) begin : g_bad_width
		$error("unsupported row or bank width");
	end

	// ************************************************************
	// command decode
	// ************************************************************
	logic cke_q;
	logic cke_d;
	cmd_e cmd;

	cmd_decode u_dec (
		.cke_prev        (cke_q),
		.clock_enable    (clock_enable),
		.chip_select_n   (chip_select_n),
		.row_strobe_n    (row_strobe_n),
		.column_strobe_n (column_strobe_n),
		.write_enable_n  (write_enable_n),
		.cmd             (cmd)
	);

	function automatic logic [7:0] sat_dec(input logic [7:0] v);
		return (v == 8'h00) ? 8'h00 : v - 8'h01;
	endfunction

	// ************************************************************
	// state, bank and counters
	// ************************************************************
	pwr_state_e              state_q,    state_d;
	logic [BANKS-1:0]        open_q,     open_d;
	logic [ROW_BITS-1:0]     row_q,      row_d;
	logic [BANK_BITS-1:0]    bank_q,     bank_d;
	logic [7:0]              tmr_q,      tmr_d;
	logic [7:0]              rd_tmr_q,   rd_tmr_d;
	logic [7:0]              self_tmr_q, self_tmr_d;
	logic                    busy_q,     busy_d;
	logic                    dll_q,      dll_d;
	logic                    iclk_q,     iclk_d;
	logic                    selfr_q,    selfr_d;
	logic                    pd_q,       pd_d;
	logic                    apd_q,      apd_d;
	logic                    rdy_q,      rdy_d;
	logic                    rrdy_q,     rrdy_d;
	logic                    oany_q,     oany_d;

	always_comb begin
		state_d    = state_q;
		open_d     = open_q;
		row_d      = row_q;
		bank_d     = bank_q;
		tmr_d      = sat_dec(tmr_q);
		rd_tmr_d   = sat_dec(rd_tmr_q);
		self_tmr_d = self_tmr_q;
		cke_d      = clock_enable;
		unique case (state_q)
			ST_IDLE: begin
				unique case (cmd)
					CMD_ACTIVATE: open_d[bank_addr] = 1'b1;
					CMD_PRECHG: begin
						if (precharge_all)
							open_d = '0;
						else
							open_d[bank_addr] = 1'b0;
					end
					CMD_REFRESH: begin
						state_d = ST_REFRESH;
						tmr_d   = 8'(REFRESH_CYCLE_CYC);
						open_d  = '0;
					end
					CMD_SELF: begin
						state_d    = ST_SELF;
						self_tmr_d = 8'(MIN_CKE_PULSE_CYC - 1);
					end
					CMD_PD_ENTER: begin
						state_d = (open_q == '0) ? ST_PRE_PD
							: ST_ACT_PD;
					end
					default: ;
				endcase
			end
			ST_REFRESH: begin
				if (cmd == CMD_PD_ENTER) begin
					// the refresh counts at once, no timer left to lose
					state_d = ST_PRE_PD;
					tmr_d   = 8'h00;
					{row_d, bank_d} = {row_q, bank_q} + 1'b1;
				end else if (tmr_q == 8'h01) begin
					state_d = ST_IDLE;
					{row_d, bank_d} = {row_q, bank_q} + 1'b1;
				end
			end
			ST_SELF: begin
				// only clock_enable is looked at here
				cke_d = clock_enable;
				if (self_tmr_q != 8'h00) begin
					self_tmr_d = self_tmr_q - 8'h01;
					if (self_tmr_q == 8'h01)
						{row_d, bank_d} = {row_q, bank_q} + 1'b1;
				end
				if (clock_enable) begin
					state_d  = ST_SELF_EXIT;
					tmr_d    = 8'(SELF_NONREAD_CYC);
					rd_tmr_d = 8'(SELF_READ_CYC);
				end
			end
			ST_SELF_EXIT: begin
				if (tmr_q <= 8'h01)
					state_d = ST_IDLE;
			end
			ST_PRE_PD, ST_ACT_PD: begin
				if (clock_enable && (chip_select_n ||
				    (row_strobe_n && column_strobe_n && write_enable_n))) begin
					state_d = ST_PD_EXIT;
					tmr_d   = 8'(PD_EXIT_CYC);
				end
			end
			ST_PD_EXIT: begin
				if (tmr_q <= 8'h01)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// ************************************************************
	// status outputs, all registered
	// ************************************************************
	always_comb begin
		busy_d  = (state_d == ST_REFRESH) ||
			(state_d == ST_SELF && self_tmr_d != 8'h00);
		dll_d   = !(state_d == ST_SELF || state_d == ST_PRE_PD ||
			(state_d == ST_ACT_PD && !fast_exit));
		iclk_d  = (state_d != ST_SELF) || (self_tmr_d != 8'h00);
		selfr_d = (state_d == ST_SELF);
		pd_d    = (state_d == ST_PRE_PD) || (state_d == ST_ACT_PD);
		apd_d   = (state_d == ST_ACT_PD);
		rdy_d   = (state_d == ST_IDLE);
		rrdy_d  = (state_d == ST_IDLE) && (rd_tmr_d == 8'h00);
		oany_d  = |open_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q    <= ST_IDLE;
			cke_q      <= 1'b0;
			open_q     <= BANKS_IDLE_RESET;
			row_q      <= '0;
			bank_q     <= '0;
			tmr_q      <= 8'h00;
			rd_tmr_q   <= 8'h00;
			self_tmr_q <= 8'h00;
			busy_q     <= 1'b0;
			dll_q      <= 1'b1;
			iclk_q     <= 1'b1;
			selfr_q    <= 1'b0;
			pd_q       <= 1'b0;
			apd_q      <= 1'b0;
			rdy_q      <= 1'b1;
			rrdy_q     <= 1'b1;
			oany_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			cke_q      <= cke_d;
			open_q     <= open_d;
			row_q      <= row_d;
			bank_q     <= bank_d;
			tmr_q      <= tmr_d;
			rd_tmr_q   <= rd_tmr_d;
			self_tmr_q <= self_tmr_d;
			busy_q     <= busy_d;
			dll_q      <= dll_d;
			iclk_q     <= iclk_d;
			selfr_q    <= selfr_d;
			pd_q       <= pd_d;
			apd_q      <= apd_d;
			rdy_q      <= rdy_d;
			rrdy_q     <= rrdy_d;
			oany_q     <= oany_d;
		end
	end

	assign refresh_busy        = busy_q;
	assign refresh_bank        = bank_q;
	assign refresh_row         = row_q;
	assign dll_enable          = dll_q;
	assign internal_clock_on   = iclk_q;
	assign self_refresh_active = selfr_q;
	assign power_down_active   = pd_q;
	assign active_power_down   = apd_q;
	assign banks_open_any      = oany_q;
	assign ready_for_read      = rrdy_q;
	assign ready_for_command   = rdy_q;
endmodule

// ==== verilog/refresh_pd_pkg.sv ====
package refresh_pd_pkg;
	// ************************************************************
	// timing figures and derived cycle counts
	// ************************************************************
	localparam int unsigned CLK_PERIOD_PS        = 25000;
	localparam int unsigned REFRESH_CYCLE_NS     = 75;
	localparam int unsigned REFRESH_CYCLE_CYC    =
		(REFRESH_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned MIN_CKE_PULSE_CYC    = 3;
	localparam int unsigned SELF_NONREAD_NS      = 85;
	localparam int unsigned SELF_NONREAD_CYC     =
		(SELF_NONREAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SELF_READ_CYC        = 200;
	localparam int unsigned PD_EXIT_CYC          = 2;
	localparam int unsigned BANKS                = 4;
	localparam int unsigned ROWS                 = 8192;
	localparam logic [3:0]  BANKS_IDLE_RESET     = 4'h0;
	localparam logic [12:0] ROW_COUNT_RESET      = 13'h0000;

	// ************************************************************
	// power and refresh states
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_REFRESH   = 3'b001,
		ST_SELF      = 3'b011,
		ST_SELF_EXIT = 3'b010,
		ST_PRE_PD    = 3'b110,
		ST_ACT_PD    = 3'b111,
		ST_PD_EXIT   = 3'b101
	} pwr_state_e;

	// ************************************************************
	// decoded commands
	// ************************************************************
	typedef enum logic [2:0] {
		CMD_NOP      = 3'h0,
		CMD_ACTIVATE = 3'h1,
		CMD_PRECHG   = 3'h2,
		CMD_REFRESH  = 3'h3,
		CMD_SELF     = 3'h4,
		CMD_PD_ENTER = 3'h5,
		CMD_OTHER    = 3'h6
	} cmd_e;
endpackage
